// >>> sie_blink.sv
/*
  Shared blink divider: half-period down-counter toggling a phase bit.
  Assumes one clock, async active-low reset and a quasi-static half period.
*/
`timescale 1ns/10ps
`default_nettype none

module sie_blink #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic [CNT_W-1:0] half_period,
  // Phase out
  output logic phase
);

  logic [CNT_W-1:0] cnt_r;
  logic phase_r;

  initial begin
    if (CNT_W < 2 || CNT_W > 31) begin
      $error("sie_blink: CNT_W out of range");
    end
  end

  // Zero half period behaves as one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (cnt_r == '0) begin
      cnt_r <= (half_period == '0) ? '0 : half_period - CNT_W'(1);
    end else begin
      cnt_r <= cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 1'b0;
    end else if (cnt_r == '0) begin
      phase_r <= ~phase_r;
    end
  end

  assign phase = phase_r;

  a_blink_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_r != '0) |=> $stable(phase_r))
    else $error("blink phase changed early");
  a_blink_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_r == '0) |=> (phase_r != $past(phase_r)))
    else $error("blink phase did not toggle");

endmodule

`default_nettype wire

// >>> sie_top.sv
/*
  Status indicator encoder: constants package and top module mapping scanner
  flags to indicator colours, with an APB register slave.
  Assumes status inputs and the APB master synchronous to pclk.
*/
// The placing of the registers and the APB slave port were left to the implementer.
// Overview of operation
// - LED 2 dark if interlock off/released, yellow flash if occupied, yellow if unlockable.
// - Four-field mode: LED 4 blue while warning field 3 is hit, else dark.
// - Four-field mode: LED 5 flashes yellow while warning field 2 is hit.
// - Power LED red on self-test or internal comm error, green flash on identify.
// - Power LED green when on and healthy, dark when off.
// - Protocol LED dark off, green flash passive/identify, green active, red on faults.
// - Network LED dark inactive, green flash init/identify, green on data exchange.
// - Network LED orange flash topology, red flash config/data fail, red bus error.
// - Port LEDs dark without link, green idle, green/orange alternating on traffic.
`timescale 1ns/10ps
`default_nettype none

package sie_pkg;
  typedef enum logic [2:0] {
    SIE_OFF, SIE_RED, SIE_GREEN, SIE_BLUE, SIE_YELLOW, SIE_ORANGE
  } sie_colour_e;
  localparam int CLK_HZ = 20_000_000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int BLK_W = 24;
  // Register byte offsets
  localparam logic [7:0] OFS_BLINK = 8'h00;
  localparam logic [7:0] OFS_LED_A = 8'h04;
  localparam logic [7:0] OFS_LED_B = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  // Interrupt bit positions
  localparam int INT_W = 5;
  localparam int EV_ERROR = 0;
  localparam int EV_SAFE_OFF = 1;
  localparam int EV_BUS_ERR = 2;
  localparam int EV_SP_ERR = 3;
  localparam int EV_LINK_DOWN = 4;
  localparam logic [INT_W-1:0] INT_MASK_RST = 5'h00;
  localparam int COL_W = 3;
endpackage

module sie_top #(
  parameter int BLINK_HALF_CYC = sie_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Safety and interlock status
  input wire logic power_on,
  input wire logic scanner_error,
  input wire logic safety_output_switch_on,
  input wire logic restart_interlock_enabled,
  input wire logic restart_interlock_released,
  input wire logic prot_field_occupied,
  input wire logic linked_sensor_enabled,
  // Warning fields
  input wire logic four_field_mode,
  input wire logic warn_field1_hit,
  input wire logic warn_field2_hit,
  input wire logic warn_field3_hit,
  // Health and identify
  input wire logic self_test_error,
  input wire logic internal_comm_error,
  input wire logic identify_blink,
  // Safety protocol layer
  input wire logic sp_initialised,
  input wire logic sp_passive,
  input wire logic sp_active,
  input wire logic sp_config_fail,
  input wire logic sp_comm_error,
  // Fieldbus layer
  input wire logic net_initialising,
  input wire logic net_data_exchange,
  input wire logic net_topology_error,
  input wire logic net_config_fail,
  input wire logic net_no_data,
  input wire logic net_invalid_data,
  input wire logic net_bus_error,
  // Ethernet ports
  input wire logic port1_link,
  input wire logic port1_activity,
  input wire logic port2_link,
  input wire logic port2_activity,
  // Indicators 1 to 11
  output sie_pkg::sie_colour_e safety_output_switch_led,
  output sie_pkg::sie_colour_e restart_interlock_led,
  output sie_pkg::sie_colour_e warn_field_led,
  output sie_pkg::sie_colour_e warn_field3_led,
  output sie_pkg::sie_colour_e warn_field2_led,
  output sie_pkg::sie_colour_e spare_led,
  output sie_pkg::sie_colour_e power_health_indicator,
  output sie_pkg::sie_colour_e safety_protocol_indicator,
  output sie_pkg::sie_colour_e network_indicator,
  output sie_pkg::sie_colour_e port_one_link_indicator,
  output sie_pkg::sie_colour_e port_two_link_indicator
);

  localparam int BW = sie_pkg::BLK_W;
  localparam int IW = sie_pkg::INT_W;
  localparam int CW = sie_pkg::COL_W;

  initial begin
    if (BLINK_HALF_CYC < 1 || BLINK_HALF_CYC >= (1 << BW)) begin
      $error("sie_top: BLINK_HALF_CYC does not fit the divider");
    end
  end

  function automatic sie_pkg::sie_colour_e flash(sie_pkg::sie_colour_e col, logic on);
    return on ? col : sie_pkg::SIE_OFF;
  endfunction

  function automatic sie_pkg::sie_colour_e port_led(logic link, logic act, logic on);
    if (!link) begin
      return sie_pkg::SIE_OFF;
    end else if (act) begin
      return on ? sie_pkg::SIE_GREEN : sie_pkg::SIE_ORANGE;
    end
    return sie_pkg::SIE_GREEN;
  endfunction

  logic blink_on;
  logic [BW-1:0] blink_half_r;
  logic [IW-1:0] int_stat_r;
  logic [IW-1:0] int_mask_r;
  logic [IW-1:0] events;
  logic [IW-1:0] rd_clr_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic err_prev_r;
  logic safe_prev_r;
  logic bus_prev_r;
  logic sp_prev_r;
  logic link_prev_r;
  logic setup;
  logic access;
  logic mapped;
  sie_pkg::sie_colour_e l1_r, l2_r, l3_r, l4_r, l5_r, l6_r, l7_r, l8_r, l9_r, l10_r, l11_r;
  sie_pkg::sie_colour_e l1_nxt, l2_nxt, l3_nxt, l4_nxt, l5_nxt, l7_nxt, l8_nxt, l9_nxt;

  sie_blink #(
    .CNT_W(BW)
  ) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .half_period(blink_half_r),
    .phase(blink_on)
  );

  // Indicator encoding
  always_comb begin
    if (!power_on) begin
      l1_nxt = sie_pkg::SIE_OFF;
    end else if (scanner_error) begin
      l1_nxt = flash(sie_pkg::SIE_RED, blink_on);
    end else if (safety_output_switch_on) begin
      l1_nxt = sie_pkg::SIE_GREEN;
    end else begin
      l1_nxt = sie_pkg::SIE_RED;
    end
    if (!power_on || !restart_interlock_enabled || restart_interlock_released) begin
      l2_nxt = sie_pkg::SIE_OFF;
    end else if (prot_field_occupied) begin
      l2_nxt = flash(sie_pkg::SIE_YELLOW, blink_on);
    end else if (linked_sensor_enabled) begin
      l2_nxt = sie_pkg::SIE_YELLOW;
    end else begin
      l2_nxt = sie_pkg::SIE_OFF;
    end
    l3_nxt = (power_on && warn_field1_hit) ? sie_pkg::SIE_BLUE : sie_pkg::SIE_OFF;
    l4_nxt = (power_on && four_field_mode && warn_field3_hit) ?
             sie_pkg::SIE_BLUE : sie_pkg::SIE_OFF;
    l5_nxt = (power_on && four_field_mode && warn_field2_hit) ?
             flash(sie_pkg::SIE_YELLOW, blink_on) : sie_pkg::SIE_OFF;
    if (!power_on) begin
      l7_nxt = sie_pkg::SIE_OFF;
    end else if (self_test_error || internal_comm_error) begin
      l7_nxt = sie_pkg::SIE_RED;
    end else if (identify_blink) begin
      l7_nxt = flash(sie_pkg::SIE_GREEN, blink_on);
    end else begin
      l7_nxt = sie_pkg::SIE_GREEN;
    end
    if (!power_on) begin
      l8_nxt = sie_pkg::SIE_OFF;
    end else if (sp_comm_error) begin
      l8_nxt = sie_pkg::SIE_RED;
    end else if (sp_config_fail) begin
      l8_nxt = flash(sie_pkg::SIE_RED, blink_on);
    end else if (identify_blink || (sp_initialised && sp_passive)) begin
      l8_nxt = flash(sie_pkg::SIE_GREEN, blink_on);
    end else if (sp_initialised && sp_active) begin
      l8_nxt = sie_pkg::SIE_GREEN;
    end else begin
      l8_nxt = sie_pkg::SIE_OFF;
    end
    if (!power_on) begin
      l9_nxt = sie_pkg::SIE_OFF;
    end else if (net_bus_error) begin
      l9_nxt = sie_pkg::SIE_RED;
    end else if (net_config_fail || net_no_data || net_invalid_data) begin
      l9_nxt = flash(sie_pkg::SIE_RED, blink_on);
    end else if (net_topology_error) begin
      l9_nxt = flash(sie_pkg::SIE_ORANGE, blink_on);
    end else if (net_initialising || identify_blink) begin
      l9_nxt = flash(sie_pkg::SIE_GREEN, blink_on);
    end else if (net_data_exchange) begin
      l9_nxt = sie_pkg::SIE_GREEN;
    end else begin
      l9_nxt = sie_pkg::SIE_OFF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      l1_r <= sie_pkg::SIE_OFF;
      l2_r <= sie_pkg::SIE_OFF;
      l3_r <= sie_pkg::SIE_OFF;
      l4_r <= sie_pkg::SIE_OFF;
      l5_r <= sie_pkg::SIE_OFF;
      l6_r <= sie_pkg::SIE_OFF;
      l7_r <= sie_pkg::SIE_OFF;
      l8_r <= sie_pkg::SIE_OFF;
      l9_r <= sie_pkg::SIE_OFF;
      l10_r <= sie_pkg::SIE_OFF;
      l11_r <= sie_pkg::SIE_OFF;
    end else begin
      l1_r <= l1_nxt;
      l2_r <= l2_nxt;
      l3_r <= l3_nxt;
      l4_r <= l4_nxt;
      l5_r <= l5_nxt;
      l6_r <= sie_pkg::SIE_OFF;
      l7_r <= l7_nxt;
      l8_r <= l8_nxt;
      l9_r <= l9_nxt;
      l10_r <= port_led(port1_link && power_on, port1_activity, blink_on);
      l11_r <= port_led(port2_link && power_on, port2_activity, blink_on);
    end
  end

  assign safety_output_switch_led = l1_r;
  assign restart_interlock_led = l2_r;
  assign warn_field_led = l3_r;
  assign warn_field3_led = l4_r;
  assign warn_field2_led = l5_r;
  assign spare_led = l6_r;
  assign power_health_indicator = l7_r;
  assign safety_protocol_indicator = l8_r;
  assign network_indicator = l9_r;
  assign port_one_link_indicator = l10_r;
  assign port_two_link_indicator = l11_r;

  // Event edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_prev_r <= 1'b0;
      safe_prev_r <= 1'b0;
      bus_prev_r <= 1'b0;
      sp_prev_r <= 1'b0;
      link_prev_r <= 1'b0;
    end else begin
      err_prev_r <= scanner_error;
      safe_prev_r <= safety_output_switch_on;
      bus_prev_r <= net_bus_error;
      sp_prev_r <= sp_comm_error;
      link_prev_r <= port1_link && port2_link;
    end
  end

  always_comb begin
    events = '0;
    events[sie_pkg::EV_ERROR] = scanner_error && !err_prev_r;
    events[sie_pkg::EV_SAFE_OFF] = safe_prev_r && !safety_output_switch_on;
    events[sie_pkg::EV_BUS_ERR] = net_bus_error && !bus_prev_r;
    events[sie_pkg::EV_SP_ERR] = sp_comm_error && !sp_prev_r;
    events[sie_pkg::EV_LINK_DOWN] = link_prev_r && !(port1_link && port2_link);
  end

  // APB slave: data captured in setup, zero-wait access
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == sie_pkg::OFS_BLINK) || (paddr == sie_pkg::OFS_LED_A) ||
                  (paddr == sie_pkg::OFS_LED_B) || (paddr == sie_pkg::OFS_INT_STAT) ||
                  (paddr == sie_pkg::OFS_INT_MASK);
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r && access;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      rd_clr_r <= '0;
    end else if (setup) begin
      pslverr_r <= !mapped;
      rd_clr_r <= '0;
      prdata_r <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          sie_pkg::OFS_BLINK: prdata_r <= {{(32-BW){1'b0}}, blink_half_r};
          sie_pkg::OFS_LED_A: prdata_r <= {14'h0000, l6_r, l5_r, l4_r, l3_r, l2_r, l1_r};
          sie_pkg::OFS_LED_B: prdata_r <= {17'h00000, l11_r, l10_r, l9_r, l8_r, l7_r};
          sie_pkg::OFS_INT_STAT: begin
            prdata_r <= {{(32-IW){1'b0}}, int_stat_r};
            rd_clr_r <= int_stat_r;
          end
          sie_pkg::OFS_INT_MASK: prdata_r <= {{(32-IW){1'b0}}, int_mask_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_half_r <= BW'(BLINK_HALF_CYC);
    end else if (access && pwrite && paddr == sie_pkg::OFS_BLINK) begin
      blink_half_r <= pwdata[BW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_r <= sie_pkg::INT_MASK_RST;
    end else if (access && pwrite && paddr == sie_pkg::OFS_INT_MASK) begin
      int_mask_r <= pwdata[IW-1:0];
    end
  end

  // Read clears only bits that were returned; new events win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= '0;
    end else if (access && !pwrite && paddr == sie_pkg::OFS_INT_STAT) begin
      int_stat_r <= (int_stat_r & ~rd_clr_r) | events;
    end else begin
      int_stat_r <= int_stat_r | events;
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  a_led1_dark: assert property (@(posedge pclk) disable iff (!presetn)
    !power_on |=> safety_output_switch_led == sie_pkg::SIE_OFF)
    else $error("indicator 1 lit while device off");
  a_led1_green: assert property (@(posedge pclk) disable iff (!presetn)
    power_on && !scanner_error && safety_output_switch_on
    |=> safety_output_switch_led == sie_pkg::SIE_GREEN)
    else $error("indicator 1 not green");
  a_led2_flash: assert property (@(posedge pclk) disable iff (!presetn)
    power_on && restart_interlock_enabled && !restart_interlock_released &&
    prot_field_occupied && blink_on |=> restart_interlock_led == sie_pkg::SIE_YELLOW)
    else $error("indicator 2 not yellow");
  a_led4_blue: assert property (@(posedge pclk) disable iff (!presetn)
    power_on && four_field_mode && warn_field3_hit
    |=> warn_field3_led == sie_pkg::SIE_BLUE)
    else $error("indicator 4 not blue");
  a_led5_flash: assert property (@(posedge pclk) disable iff (!presetn)
    power_on && four_field_mode && warn_field2_hit && !blink_on
    |=> warn_field2_led == sie_pkg::SIE_OFF)
    else $error("indicator 5 lit when dark");
  a_pwr_red: assert property (@(posedge pclk) disable iff (!presetn)
    power_on && self_test_error |=> power_health_indicator == sie_pkg::SIE_RED)
    else $error("power LED not red");
  a_pwr_green: assert property (@(posedge pclk) disable iff (!presetn)
    power_on && !self_test_error && !internal_comm_error && !identify_blink
    |=> power_health_indicator == sie_pkg::SIE_GREEN)
    else $error("power LED not green");
  a_sp_red: assert property (@(posedge pclk) disable iff (!presetn)
    power_on && sp_comm_error |=> safety_protocol_indicator == sie_pkg::SIE_RED)
    else $error("protocol LED not red");
  a_net_green: assert property (@(posedge pclk) disable iff (!presetn)
    power_on && net_data_exchange && !net_bus_error && !net_config_fail && !net_no_data &&
    !net_invalid_data && !net_topology_error && !net_initialising && !identify_blink
    |=> network_indicator == sie_pkg::SIE_GREEN)
    else $error("network LED not green");
  a_net_orange: assert property (@(posedge pclk) disable iff (!presetn)
    power_on && net_topology_error && !net_bus_error && !net_config_fail && !net_no_data &&
    !net_invalid_data && blink_on |=> network_indicator == sie_pkg::SIE_ORANGE)
    else $error("network LED not orange");
  a_port_alt: assert property (@(posedge pclk) disable iff (!presetn)
    power_on && port1_link && port1_activity && !blink_on
    |=> port_one_link_indicator == sie_pkg::SIE_ORANGE)
    else $error("port LED not orange");
  a_int_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    events[sie_pkg::EV_ERROR] |=> int_stat_r[sie_pkg::EV_ERROR])
    else $error("error event not latched");

  c_port_traffic: cover property (@(posedge pclk) disable iff (!presetn)
    port_one_link_indicator == sie_pkg::SIE_ORANGE);
  c_net_exchange: cover property (@(posedge pclk) disable iff (!presetn)
    network_indicator == sie_pkg::SIE_GREEN);
  c_unlockable: cover property (@(posedge pclk) disable iff (!presetn)
    restart_interlock_led == sie_pkg::SIE_YELLOW [*2]);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule

`default_nettype wire

// >>> sie_viewer.sv
/*
  Operator model: tallies what one indicator shows.
  Assumes sampling on pclk and a clr pulse from the bench.
*/
`timescale 1ns/10ps
`default_nettype none

module sie_viewer (
  // Clock, reset and clear
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  // Indicator under view
  input wire sie_pkg::sie_colour_e led,
  // Tallies since the last clear
  output logic [15:0] lit,
  output logic [15:0] dark,
  output logic [15:0] edges,
  output sie_pkg::sie_colour_e col_a,
  output sie_pkg::sie_colour_e col_b
);
  sie_pkg::sie_colour_e prev_r;

  always @(posedge pclk) begin
    if (!presetn || clr) begin
      lit <= 16'h0000;
      dark <= 16'h0000;
      edges <= 16'h0000;
      col_a <= sie_pkg::SIE_OFF;
      col_b <= sie_pkg::SIE_OFF;
    end else begin
      if (led == sie_pkg::SIE_OFF) dark <= dark + 16'h0001;
      else lit <= lit + 16'h0001;
      if (led != prev_r) edges <= edges + 16'h0001;
      // First lit colour, then any second lit colour
      if (col_a == sie_pkg::SIE_OFF) col_a <= led;
      else if (led != sie_pkg::SIE_OFF && led != col_a) col_b <= led;
    end
    prev_r <= led;
  end
endmodule

`default_nettype wire

// >>> tb_status_indicator_encoder.sv
/*
  Self-checking bench: drives scanner flags and APB, judges each
  indicator through the operator model. Assumes sie_top and sie_viewer.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_status_indicator_encoder;
  typedef struct packed {
    logic power_on, scanner_error, safety_output_switch_on, restart_interlock_enabled;
    logic restart_interlock_released, prot_field_occupied, linked_sensor_enabled;
    logic four_field_mode, warn_field1_hit, warn_field2_hit, warn_field3_hit;
    logic self_test_error, internal_comm_error, identify_blink, sp_initialised;
    logic sp_passive, sp_active, sp_config_fail, sp_comm_error, net_initialising;
    logic net_data_exchange, net_topology_error, net_config_fail, net_no_data;
    logic net_invalid_data, net_bus_error, port1_link, port1_activity;
    logic port2_link, port2_activity;
  } sie_tb_in_s;
  localparam int HALF = 4;
  localparam int DARK = 0;
  localparam int STEADY = 1;
  localparam int FLASH = 2;
  localparam int ALT = 3;
  localparam sie_pkg::sie_colour_e OFF_C = sie_pkg::SIE_OFF;
  localparam sie_pkg::sie_colour_e RED_C = sie_pkg::SIE_RED;
  localparam sie_pkg::sie_colour_e GRN_C = sie_pkg::SIE_GREEN;
  localparam sie_pkg::sie_colour_e YEL_C = sie_pkg::SIE_YELLOW;
  sie_tb_in_s s;
  logic pclk, presetn, psel, penable, pwrite, clr, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lit, dark, edges, e_seen;
  sie_pkg::sie_colour_e led [11];
  sie_pkg::sie_colour_e seen, col_a, col_b;
  int sel, num_errors, tests_run;

  assign seen = led[sel];

  sie_top #(.BLINK_HALF_CYC(HALF)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .power_on(s.power_on), .scanner_error(s.scanner_error),
    .safety_output_switch_on(s.safety_output_switch_on),
    .restart_interlock_enabled(s.restart_interlock_enabled),
    .restart_interlock_released(s.restart_interlock_released),
    .prot_field_occupied(s.prot_field_occupied),
    .linked_sensor_enabled(s.linked_sensor_enabled), .four_field_mode(s.four_field_mode),
    .warn_field1_hit(s.warn_field1_hit), .warn_field2_hit(s.warn_field2_hit),
    .warn_field3_hit(s.warn_field3_hit), .self_test_error(s.self_test_error),
    .internal_comm_error(s.internal_comm_error), .identify_blink(s.identify_blink),
    .sp_initialised(s.sp_initialised), .sp_passive(s.sp_passive), .sp_active(s.sp_active),
    .sp_config_fail(s.sp_config_fail), .sp_comm_error(s.sp_comm_error),
    .net_initialising(s.net_initialising), .net_data_exchange(s.net_data_exchange),
    .net_topology_error(s.net_topology_error), .net_config_fail(s.net_config_fail),
    .net_no_data(s.net_no_data), .net_invalid_data(s.net_invalid_data),
    .net_bus_error(s.net_bus_error), .port1_link(s.port1_link),
    .port1_activity(s.port1_activity), .port2_link(s.port2_link),
    .port2_activity(s.port2_activity), .safety_output_switch_led(led[0]),
    .restart_interlock_led(led[1]), .warn_field_led(led[2]), .warn_field3_led(led[3]),
    .warn_field2_led(led[4]), .spare_led(led[5]), .power_health_indicator(led[6]),
    .safety_protocol_indicator(led[7]), .network_indicator(led[8]),
    .port_one_link_indicator(led[9]), .port_two_link_indicator(led[10]));

  sie_viewer i_view (.pclk(pclk), .presetn(presetn), .clr(clr), .led(seen), .lit(lit),
    .dark(dark), .edges(edges), .col_a(col_a), .col_b(col_b));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Judges one indicator's pattern and colours over 32 cycles
  task automatic look(input int idx, input int kind, input sie_pkg::sie_colour_e ca,
      input sie_pkg::sie_colour_e cb = sie_pkg::SIE_OFF);
    int k;
    sel = idx;
    repeat (3) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (32) @(posedge pclk);
    e_seen = edges;
    k = (lit == 0) ? DARK : (dark != 0) ? FLASH : (col_b != OFF_C) ? ALT : STEADY;
    tests_run++;
    if (k != kind || !((col_a === ca && col_b === cb) || (col_a === cb && col_b === ca)))
    begin
      num_errors++;
      $display("ERROR led%0d expected %0d %s %s seen %0d %s %s", idx + 1, kind, ca.name(),
        cb.name(), k, col_a.name(), col_b.name());
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_blink();
    apb(1'b0, sie_pkg::OFS_BLINK, 32'h0);
    cmp32("blink reset", HALF, rd);
    s.scanner_error <= 1'b1;
    s.power_on <= 1'b1;
    look(0, FLASH, RED_C);
    cmp32("toggles half 4", 1, {31'h0, e_seen >= 7 && e_seen <= 8});
    apb(1'b1, sie_pkg::OFS_BLINK, 32'h8);
    apb(1'b0, sie_pkg::OFS_BLINK, 32'h0);
    cmp32("blink rw", 32'h8, rd);
    look(0, FLASH, RED_C);
    cmp32("toggles half 8", 1, {31'h0, e_seen >= 3 && e_seen <= 4});
    apb(1'b1, sie_pkg::OFS_BLINK, HALF);
  endtask

  task automatic t_led1();
    s <= '0;
    look(0, DARK, OFF_C);
    s.power_on <= 1'b1;
    look(0, STEADY, RED_C);
    s.safety_output_switch_on <= 1'b1;
    look(0, STEADY, GRN_C);
    s.restart_interlock_enabled <= 1'b0;
    look(1, DARK, OFF_C);
    s.restart_interlock_enabled <= 1'b1;
    s.prot_field_occupied <= 1'b1;
    look(1, FLASH, YEL_C);
    s.prot_field_occupied <= 1'b0;
    s.linked_sensor_enabled <= 1'b1;
    look(1, STEADY, YEL_C);
    s.restart_interlock_released <= 1'b1;
    look(1, DARK, OFF_C);
    s.four_field_mode <= 1'b1;
    s.warn_field3_hit <= 1'b1;
    look(3, STEADY, sie_pkg::SIE_BLUE);
    s.warn_field3_hit <= 1'b0;
    look(3, DARK, OFF_C);
    s.warn_field2_hit <= 1'b1;
    look(4, FLASH, YEL_C);
    s.warn_field1_hit <= 1'b1;
    look(2, STEADY, sie_pkg::SIE_BLUE);
    look(5, DARK, OFF_C);
  endtask

  task automatic t_health();
    s <= '0;
    look(6, DARK, OFF_C);
    s.power_on <= 1'b1;
    look(6, STEADY, GRN_C);
    look(7, DARK, OFF_C);
    look(8, DARK, OFF_C);
    s.identify_blink <= 1'b1;
    look(6, FLASH, GRN_C);
    look(7, FLASH, GRN_C);
    look(8, FLASH, GRN_C);
    s.identify_blink <= 1'b0;
    s.self_test_error <= 1'b1;
    look(6, STEADY, RED_C);
    s.self_test_error <= 1'b0;
    s.internal_comm_error <= 1'b1;
    look(6, STEADY, RED_C);
    s.sp_initialised <= 1'b1;
    s.sp_passive <= 1'b1;
    look(7, FLASH, GRN_C);
    s.sp_passive <= 1'b0;
    s.sp_active <= 1'b1;
    look(7, STEADY, GRN_C);
    s.sp_config_fail <= 1'b1;
    look(7, FLASH, RED_C);
    s.sp_config_fail <= 1'b0;
    s.sp_comm_error <= 1'b1;
    look(7, STEADY, RED_C);
  endtask

  task automatic t_net();
    s <= '0;
    s.power_on <= 1'b1;
    s.net_initialising <= 1'b1;
    look(8, FLASH, GRN_C);
    s.net_initialising <= 1'b0;
    s.net_data_exchange <= 1'b1;
    look(8, STEADY, GRN_C);
    s.net_topology_error <= 1'b1;
    look(8, FLASH, sie_pkg::SIE_ORANGE);
    s.net_topology_error <= 1'b0;
    s.net_config_fail <= 1'b1;
    look(8, FLASH, RED_C);
    s.net_config_fail <= 1'b0;
    s.net_no_data <= 1'b1;
    look(8, FLASH, RED_C);
    s.net_no_data <= 1'b0;
    s.net_invalid_data <= 1'b1;
    look(8, FLASH, RED_C);
    s.net_bus_error <= 1'b1;
    look(8, STEADY, RED_C);
    look(9, DARK, OFF_C);
    s.port1_link <= 1'b1;
    s.port2_link <= 1'b1;
    look(9, STEADY, GRN_C);
    look(10, STEADY, GRN_C);
    s.port1_activity <= 1'b1;
    s.port2_activity <= 1'b1;
    look(9, ALT, GRN_C, sie_pkg::SIE_ORANGE);
    look(10, ALT, GRN_C, sie_pkg::SIE_ORANGE);
  endtask

  task automatic t_regs();
    s <= '0;
    s.power_on <= 1'b1;
    s.safety_output_switch_on <= 1'b1;
    s.port1_link <= 1'b1;
    s.port2_link <= 1'b1;
    apb(1'b0, sie_pkg::OFS_INT_MASK, 32'h0);
    cmp32("mask reset", 32'h0, rd);
    apb(1'b0, sie_pkg::OFS_INT_STAT, 32'h0);
    apb(1'b0, sie_pkg::OFS_INT_STAT, 32'h0);
    cmp32("status cleared", 32'h0, rd);
    apb(1'b1, sie_pkg::OFS_LED_A, 32'h7);
    apb(1'b0, sie_pkg::OFS_LED_A, 32'h0);
    cmp32("led a", 32'h2, rd);
    apb(1'b0, sie_pkg::OFS_LED_B, 32'h0);
    cmp32("led b", 32'h2402, rd);
    apb(1'b0, 8'h14, 32'h0);
    cmp32("unmapped err", 32'h1, {31'h0, err});
    cmp32("unmapped data", 32'h0, rd);
    apb(1'b1, sie_pkg::OFS_INT_MASK, 32'h1);
    s.scanner_error <= 1'b1;
    repeat (3) @(posedge pclk);
    cmp32("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, sie_pkg::OFS_INT_STAT, 32'h0);
    cmp32("status error", 32'h1, rd);
    @(posedge pclk);
    cmp32("irq cleared", 32'h0, {31'h0, irq});
    s.net_bus_error <= 1'b1;
    repeat (3) @(posedge pclk);
    cmp32("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, sie_pkg::OFS_INT_MASK, 32'h1F);
    s.sp_comm_error <= 1'b1;
    s.safety_output_switch_on <= 1'b0;
    s.port1_link <= 1'b0;
    repeat (3) @(posedge pclk);
    cmp32("irq events", 32'h1, {31'h0, irq});
    apb(1'b0, sie_pkg::OFS_INT_STAT, 32'h0);
    cmp32("status events", 32'h1E, rd);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    $display("ERROR watchdog expected done seen timeout");
    report_and_stop();
  end

  initial begin
    num_errors = 0;
    tests_run = 0;
    s = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clr = 1'b0;
    sel = 0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_blink();
    t_led1();
    t_health();
    t_net();
    t_regs();
    report_and_stop();
  end
endmodule

`default_nettype wire
